// ==== hdl/byte_fifo.sv ====
// Parameterised valid/ready FIFO
`timescale 1ns/1ns
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W:0] count_reg;
  logic push;
  logic pop;

  assign in_ready_o = (count_reg != (PTR_W+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = store[rd_ptr_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clock_i) begin
    if (push) begin
      store[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hdl/eeprom_port_pkg.sv ====
// Constants and types for the two-wire storage slave port
package eeprom_port_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_MHZ = 250;
  localparam int WRITE_CYCLE_US = 5000;
  localparam int WRITE_CYCLE_COUNT = WRITE_CYCLE_US * CLOCK_MHZ;
  localparam int TIMER_W = 21;
  localparam int DRAIN_DIV = 4;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int MEM_BYTES = 32768;
  localparam int MEM_ADDR_W = 15;
  localparam int PAGE_BYTES = 64;
  localparam int POS_W = 6;
  localparam int PAGE_W = 9;

  // ----------------------------------------------------------------
  // Address byte layout
  // ----------------------------------------------------------------
  // Device type value is arbitrary
  localparam logic [3:0] DEVICE_TYPE = 4'h6;
  localparam int ADDR_TYPE_HI = 7;
  localparam int ADDR_TYPE_LO = 4;
  localparam int ADDR_ZERO_BIT = 3;
  localparam int ADDR_STRAP_HI = 2;
  localparam int ADDR_STRAP_LO = 1;
  localparam int ADDR_DIR_BIT = 0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] LAST_TX_BIT = 3'h7;

  // ----------------------------------------------------------------
  // Control byte
  // ----------------------------------------------------------------
  localparam logic [15:0] CTRL_ADDR = 16'hFFFF;
  localparam logic [7:0] CTRL_LATCH_SET = 8'h02;
  localparam logic [7:0] CTRL_LATCH_CLR = 8'h00;
  localparam int CTRL_GUARD_BIT = 7;
  localparam int CTRL_BP_HI = 4;
  localparam int CTRL_BP_LO = 3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_WORD_HI = 2'b01,
    PH_WORD_LO = 2'b10,
    PH_DATA = 2'b11
  } phase_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_RACK = 3'b100
  } state_t;

  typedef struct packed {
    logic [MEM_ADDR_W-1:0] addr;
    logic [7:0] data;
  } wr_entry_t;

endpackage

// ==== hdl/eeprom_slave_port.sv ====
// Two-wire slave port with page buffer, write queue and storage array
//
// Behaviour
// R1: Data changes only while clock low; high-clock edges mean start or stop.
// R2: Watch for start always; ignore traffic until a start is seen.
// R3: Stop ends the sequence and returns the port to standby.
// R4: Transmitter releases after eight bits; receiver pulls low on ninth.
// R5: Acknowledge matching address, and every byte while selected for write; code acks only one data byte at the control address.
// R6: Read: send eight bits, sample acknowledge, continue on ack, stop on none.
// R7: Master issues stop after withholding acknowledge on a read.
// R8: Address byte: type field, zero bit, two strap bits, direction bit.
// R9: Type or strap mismatch: no acknowledge, back to standby.
// R10: Direction one reads, direction zero writes.
// R11: Master gives an explicit word address in its first transaction.
// R12: 512 pages of 64 bytes; page from first byte and bits 7:6.
// R13: In-page position from bits 5:0 of second word-address byte.
// R14: Byte write: three bytes plus data acknowledged; stop starts the write.
// R15: During the write cycle ignore inputs, answer nothing, release data line.
// R16: Accept up to 64 data bytes in one page write.
// R17: After each written byte increment only the in-page position.
// R18: Position wraps from the last byte to the first of the page.
// R19: Extra bytes replace earlier buffered bytes at the same position.
// R20: Stop before a complete data byte and ack abandons without writing.
// R21: Master keeps straps and protect pin stable from start to stop.
// R22: Protect pin high with guard bit set refuses protection bit changes.
// R23: No address acknowledge while the write cycle runs.
// R24: Store latch clear: ignore writes and withhold data acknowledge.
// R25: Write cycle length is a parameter counted in clock cycles.
`timescale 1ns/1ns
`default_nettype none
module eeprom_slave_port #(
  parameter int WRITE_CYCLES = eeprom_port_pkg::WRITE_CYCLE_COUNT
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Two-wire bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Straps and protect pin
  input wire logic select_strap_low_i,
  input wire logic select_strap_high_i,
  input wire logic write_protect_i,
  // Status
  output logic busy_o,
  output logic store_write_latch_o,
  output logic guard_pin_enable_bit_o,
  output logic [1:0] block_protect_o
);
  // ----------------------------------------------------------------
  // Pin synchronisers and bus events
  // ----------------------------------------------------------------
  logic [4:0] pin_meta_reg;
  logic [4:0] pin_sync_reg;
  logic [1:0] line_prev_reg;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_evt;
  logic stop_evt;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_reg <= 5'h03;
      pin_sync_reg <= 5'h03;
      line_prev_reg <= 2'h3;
    end else begin
      pin_meta_reg <= {write_protect_i, select_strap_high_i,
                       select_strap_low_i, sda_i, scl_i};
      pin_sync_reg <= pin_meta_reg;
      line_prev_reg <= pin_sync_reg[1:0];
    end
  end

  assign scl = pin_sync_reg[0];
  assign sda = pin_sync_reg[1];
  assign scl_rise = scl && !line_prev_reg[0];
  assign scl_fall = !scl && line_prev_reg[0];
  // Data edges while clock stays high are framing only
  assign start_evt = scl && line_prev_reg[0] && line_prev_reg[1] && !sda; // see R1 R2
  assign stop_evt = scl && line_prev_reg[0] && !line_prev_reg[1] && sda; // see R1 R3

  // ----------------------------------------------------------------
  // Shared state
  // ----------------------------------------------------------------
  eeprom_port_pkg::state_t state_reg;
  eeprom_port_pkg::phase_t phase_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic read_reg;
  logic ack_seen_reg;
  logic [15:0] addr_reg;
  logic ctrl_sel_reg;
  logic got_data_reg;
  logic [7:0] ctrl_data_reg;
  logic latch_reg;
  logic guard_reg;
  logic [1:0] bp_reg;
  logic [eeprom_port_pkg::TIMER_W-1:0] timer_reg;
  logic committing_reg;
  logic [eeprom_port_pkg::POS_W-1:0] cidx_reg;
  logic [eeprom_port_pkg::PAGE_W-1:0] page_reg;
  logic [7:0] page_buf [eeprom_port_pkg::PAGE_BYTES];
  logic [eeprom_port_pkg::PAGE_BYTES-1:0] page_valid_reg;
  logic [7:0] mem [eeprom_port_pkg::MEM_BYTES];
  logic busy;
  logic byte_done;
  logic ack_end;
  logic addr_match;
  logic ack_ok;
  logic commit_go;
  logic ctrl_stop;
  logic guarded;
  logic nv_go;
  logic load_tx;
  eeprom_port_pkg::wr_entry_t q_in;
  eeprom_port_pkg::wr_entry_t q_out;
  logic q_in_valid;
  logic q_in_ready;
  logic q_out_valid;
  logic drain_tick;

  assign byte_done = (state_reg == eeprom_port_pkg::ST_RX) && scl_fall &&
                     (bit_cnt_reg == eeprom_port_pkg::BITS_PER_BYTE);
  assign ack_end = (state_reg == eeprom_port_pkg::ST_ACK) && scl_fall;

  // Type, zero bit and straps checked on every address byte
  assign addr_match =
    (shift_reg[eeprom_port_pkg::ADDR_TYPE_HI:eeprom_port_pkg::ADDR_TYPE_LO]
     == eeprom_port_pkg::DEVICE_TYPE) &&
    !shift_reg[eeprom_port_pkg::ADDR_ZERO_BIT] &&
    (shift_reg[eeprom_port_pkg::ADDR_STRAP_HI:eeprom_port_pkg::ADDR_STRAP_LO]
     == pin_sync_reg[3:2]); // see R8

  always_comb begin
    unique case (phase_reg)
      eeprom_port_pkg::PH_ADDR: ack_ok = addr_match; // see R5 R9
      eeprom_port_pkg::PH_WORD_HI: ack_ok = 1'b1;
      eeprom_port_pkg::PH_WORD_LO: ack_ok = 1'b1;
      // Control byte takes one byte; array needs the latch
      eeprom_port_pkg::PH_DATA: ack_ok = ctrl_sel_reg ? !got_data_reg
                                                      : latch_reg; // see R24
    endcase
  end

  assign load_tx = (ack_end && phase_reg == eeprom_port_pkg::PH_ADDR &&
                    read_reg) ||
                   (state_reg == eeprom_port_pkg::ST_RACK && scl_fall &&
                    ack_seen_reg);

  // ----------------------------------------------------------------
  // Protocol state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= eeprom_port_pkg::ST_IDLE;
      phase_reg <= eeprom_port_pkg::PH_ADDR;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      read_reg <= 1'b0;
      ack_seen_reg <= 1'b0;
    end else if (stop_evt) begin
      state_reg <= eeprom_port_pkg::ST_IDLE; // see R3
    end else if (start_evt) begin
      // Busy write cycle: no address acknowledge, no answer at all
      if (!busy) begin // see R15 R23
        state_reg <= eeprom_port_pkg::ST_RX;
        phase_reg <= eeprom_port_pkg::PH_ADDR;
        bit_cnt_reg <= 4'h0;
      end
    end else begin
      unique case (state_reg)
        eeprom_port_pkg::ST_IDLE: begin
        end
        eeprom_port_pkg::ST_RX: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            if (ack_ok) begin
              state_reg <= eeprom_port_pkg::ST_ACK; // see R4 R5
              if (phase_reg == eeprom_port_pkg::PH_ADDR) begin
                read_reg <= shift_reg[eeprom_port_pkg::ADDR_DIR_BIT]; // see R10
              end
            end else begin
              state_reg <= eeprom_port_pkg::ST_IDLE; // see R9 R24
            end
          end
        end
        eeprom_port_pkg::ST_ACK: begin
          if (ack_end) begin
            bit_cnt_reg <= 4'h0;
            if (load_tx) begin
              state_reg <= eeprom_port_pkg::ST_TX;
            end else begin
              state_reg <= eeprom_port_pkg::ST_RX;
            end
            unique case (phase_reg)
              eeprom_port_pkg::PH_ADDR: phase_reg <= eeprom_port_pkg::PH_WORD_HI;
              eeprom_port_pkg::PH_WORD_HI: phase_reg <= eeprom_port_pkg::PH_WORD_LO;
              eeprom_port_pkg::PH_WORD_LO: phase_reg <= eeprom_port_pkg::PH_DATA;
              eeprom_port_pkg::PH_DATA: phase_reg <= eeprom_port_pkg::PH_DATA;
            endcase
          end
        end
        eeprom_port_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg[2:0] == eeprom_port_pkg::LAST_TX_BIT) begin
              state_reg <= eeprom_port_pkg::ST_RACK; // see R4 R6
            end else begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        eeprom_port_pkg::ST_RACK: begin
          if (scl_rise) begin
            ack_seen_reg <= !sda;
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            state_reg <= ack_seen_reg ? eeprom_port_pkg::ST_TX
                                      : eeprom_port_pkg::ST_IDLE; // see R6
          end
        end
        default: state_reg <= eeprom_port_pkg::ST_IDLE;
      endcase
      if (load_tx) begin
        tx_reg <= mem[addr_reg[eeprom_port_pkg::MEM_ADDR_W-1:0]];
      end
    end
  end

  // ----------------------------------------------------------------
  // Word address, page buffer and control byte capture
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_reg <= 16'h0000;
      ctrl_sel_reg <= 1'b0;
      got_data_reg <= 1'b0;
      ctrl_data_reg <= 8'h00;
      page_reg <= '0;
      page_valid_reg <= '0;
    end else if (start_evt && !busy) begin
      got_data_reg <= 1'b0;
      page_valid_reg <= '0;
    end else if (load_tx && !stop_evt) begin
      addr_reg <= addr_reg + 16'h0001;
    end else if (ack_end && !stop_evt && !start_evt) begin
      unique case (phase_reg)
        eeprom_port_pkg::PH_ADDR: begin
        end
        eeprom_port_pkg::PH_WORD_HI: addr_reg[15:8] <= shift_reg; // see R12
        eeprom_port_pkg::PH_WORD_LO: begin
          addr_reg[7:0] <= shift_reg; // see R12 R13
          ctrl_sel_reg <= ({addr_reg[15:8], shift_reg} ==
                           eeprom_port_pkg::CTRL_ADDR);
        end
        eeprom_port_pkg::PH_DATA: if (!read_reg) begin
          // Byte counts only once its acknowledge is complete
          got_data_reg <= 1'b1; // see R20
          ctrl_data_reg <= shift_reg;
          page_reg <= addr_reg[14:6]; // see R12
          page_valid_reg[addr_reg[5:0]] <= 1'b1; // see R16 R19
          addr_reg[5:0] <= addr_reg[5:0] + 6'h01; // see R17 R18
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (ack_end && phase_reg == eeprom_port_pkg::PH_DATA && !read_reg) begin
      page_buf[addr_reg[5:0]] <= shift_reg; // see R19
    end
  end

  // ----------------------------------------------------------------
  // Control latch and protection bits
  // ----------------------------------------------------------------
  assign ctrl_stop = stop_evt && ctrl_sel_reg && got_data_reg &&
                     state_reg != eeprom_port_pkg::ST_IDLE;
  assign guarded = pin_sync_reg[4] && guard_reg; // see R22
  assign nv_go = ctrl_stop && latch_reg && !guarded &&
                 ctrl_data_reg != eeprom_port_pkg::CTRL_LATCH_SET &&
                 ctrl_data_reg != eeprom_port_pkg::CTRL_LATCH_CLR;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_reg <= 1'b0;
      guard_reg <= 1'b0;
      bp_reg <= 2'b00;
    end else if (ctrl_stop) begin
      if (ctrl_data_reg == eeprom_port_pkg::CTRL_LATCH_SET) begin
        latch_reg <= 1'b1;
      end else if (ctrl_data_reg == eeprom_port_pkg::CTRL_LATCH_CLR) begin
        latch_reg <= 1'b0;
      end else if (nv_go) begin
        guard_reg <= ctrl_data_reg[eeprom_port_pkg::CTRL_GUARD_BIT]; // see R22
        bp_reg <= ctrl_data_reg[eeprom_port_pkg::CTRL_BP_HI:
                                eeprom_port_pkg::CTRL_BP_LO];
      end
    end
  end

  // ----------------------------------------------------------------
  // Self-timed write cycle and page commit
  // ----------------------------------------------------------------
  // A stop past the first bit of a byte means a cut byte: no write
  assign commit_go = stop_evt && !ctrl_sel_reg && got_data_reg &&
                     state_reg != eeprom_port_pkg::ST_IDLE &&
                     bit_cnt_reg <= 4'h1; // see R14 R20
  assign busy = (timer_reg != '0) || committing_reg || q_out_valid;
  assign q_in_valid = committing_reg && page_valid_reg[cidx_reg];
  assign q_in = '{addr: {page_reg, cidx_reg}, data: page_buf[cidx_reg]};

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_reg <= '0;
    end else if (commit_go || nv_go) begin
      timer_reg <= eeprom_port_pkg::TIMER_W'(WRITE_CYCLES); // see R25
    end else if (timer_reg != '0) begin
      timer_reg <= timer_reg - 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      committing_reg <= 1'b0;
      cidx_reg <= '0;
    end else if (commit_go) begin
      committing_reg <= 1'b1;
      cidx_reg <= '0;
    end else if (committing_reg && (!q_in_valid || q_in_ready)) begin
      cidx_reg <= cidx_reg + 1'b1;
      if (cidx_reg == eeprom_port_pkg::POS_W'(eeprom_port_pkg::PAGE_BYTES-1)) begin
        committing_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Array write queue and drain pacing
  // ----------------------------------------------------------------
  logic [1:0] drain_cnt_reg;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drain_cnt_reg <= 2'h0;
    end else begin
      drain_cnt_reg <= drain_cnt_reg + 2'h1;
    end
  end
  assign drain_tick = (drain_cnt_reg == 2'(eeprom_port_pkg::DRAIN_DIV-1));

  byte_fifo #(
    .WIDTH($bits(eeprom_port_pkg::wr_entry_t)),
    .DEPTH(eeprom_port_pkg::FIFO_DEPTH)
  ) u_queue (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(q_in_valid),
    .in_ready_o(q_in_ready),
    .in_data_i(q_in),
    .out_valid_o(q_out_valid),
    .out_ready_i(drain_tick),
    .out_data_o(q_out)
  );

  always_ff @(posedge clock_i) begin
    if (q_out_valid && drain_tick) begin
      mem[q_out.addr] <= q_out.data;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      busy_o <= 1'b0;
      store_write_latch_o <= 1'b0;
      guard_pin_enable_bit_o <= 1'b0;
      block_protect_o <= 2'b00;
    end else begin
      sda_o <= 1'b0;
      // Open drain: pull low for ack or a zero data bit only
      sda_oe_o <= (state_reg == eeprom_port_pkg::ST_ACK) ||
                  (state_reg == eeprom_port_pkg::ST_TX && !tx_reg[7]); // see R4 R15
      busy_o <= busy;
      store_write_latch_o <= latch_reg;
      guard_pin_enable_bit_o <= guard_reg;
      block_protect_o <= bp_reg;
    end
  end
endmodule
`default_nettype wire

// ==== sim/bus_master_model.sv ====
// Two-wire bus master model with open-drain data pull
`timescale 1ns/1ns
`default_nettype none
module bus_master_model #(
  parameter int HALF = 16
) (
  // Clock and bus
  input wire logic clock_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  task automatic wt();
    repeat (HALF) @(negedge clock_i);
  endtask
  task automatic start();
    sda_pull_o = 1'b0;
    wt();
    scl_o = 1'b1;
    wt();
    sda_pull_o = 1'b1;
    wt();
    scl_o = 1'b0;
  endtask
  task automatic stop();
    repeat (4) @(negedge clock_i);
    sda_pull_o = 1'b1;
    wt();
    scl_o = 1'b1;
    wt();
    sda_pull_o = 1'b0;
    wt();
  endtask
  // One clock pulse; data set well inside the low phase
  task automatic clk_bit(input logic pull, output logic seen);
    repeat (4) @(negedge clock_i);
    sda_pull_o = pull;
    wt();
    scl_o = 1'b1;
    wt();
    seen = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(!b[i], s);
    clk_bit(1'b0, s);
    ack = !s;
  endtask
  task automatic rd_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b0, b[i]);
    clk_bit(ack, s);
  endtask
endmodule
`default_nettype wire

// ==== sim/eeprom_port_checker_properties.sv ====
// Concurrent checks on the slave port pins and status
`timescale 1ns/1ns
`default_nettype none
module eeprom_port_checker #(
  parameter int WRITE_CYCLES = 50
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Bus and status
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic busy_o,
  input wire logic store_write_latch_o
);
  int busy_cnt_reg;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  // Length of the current busy spell
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_cnt_reg <= 0;
    end else begin
      busy_cnt_reg <= busy_o ? busy_cnt_reg + 1 : 0;
    end
  end

  open_drain_a: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  edge_low_a: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
    else $error("data drive changed while bus clock high");
  ack_hold_a: assert property ($rose(sda_oe_o) |=> sda_oe_o [*8])
    else $error("data drive released too early");
  busy_quiet_a: assert property (busy_o |-> !sda_oe_o)
    else $error("data line driven during write cycle");
  busy_start_a: assert property ($rose(busy_o) |-> scl_i && sda_i)
    else $error("write cycle began without a stop");
  busy_min_a: assert property ($fell(busy_o) |-> busy_cnt_reg >= WRITE_CYCLES - 1)
    else $error("write cycle too short");
  busy_max_a: assert property (busy_o |-> busy_cnt_reg < WRITE_CYCLES + 300)
    else $error("write cycle too long");
  latch_idle_a: assert property ($changed(store_write_latch_o) |-> !busy_o)
    else $error("write latch changed during write cycle");
endmodule

bind eeprom_slave_port eeprom_port_checker #(
  .WRITE_CYCLES(WRITE_CYCLES)
) chk_i (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .busy_o(busy_o),
  .store_write_latch_o(store_write_latch_o)
);
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the two-wire storage slave port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int WC = 200;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sl = 1'b0;
  logic sh = 1'b0;
  logic wp = 1'b0;
  logic scl, pull, sda_oe, sda_o, busy, store_write_latch, gp;
  logic [1:0] bp;
  logic [7:0] q[$];
  logic [7:0] res;
  logic [15:0] rng = 16'h70C8;
  event res_ev;
  int num_errors = 0;
  int n_checks = 0;
  wire logic sda = !(sda_oe || pull);

  eeprom_slave_port #(.WRITE_CYCLES(WC)) dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .select_strap_low_i(sl),
    .select_strap_high_i(sh), .write_protect_i(wp), .busy_o(busy),
    .store_write_latch_o(store_write_latch), .guard_pin_enable_bit_o(gp),
    .block_protect_o(bp)
  );
  bus_master_model m (
    .clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial forever #2 clock_i = ~clock_i;
  function automatic logic [7:0] rnd();
    rng ^= rng << 7;
    rng ^= rng >> 9;
    rng ^= rng << 8;
    return rng[7:0];
  endfunction
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (e !== g) begin
      num_errors++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic conclude();
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic put(input logic [7:0] b, input logic e);
    logic a;
    q.push_back({7'h00, e});
    m.wr_byte(b, a);
    res = {7'h00, a};
    -> res_ev;
  endtask
  task automatic get(input logic [7:0] e, input logic ack);
    q.push_back(e);
    m.rd_byte(ack, res);
    -> res_ev;
  endtask
  task automatic sel(input logic rw, input logic e);
    m.start();
    put({eeprom_port_pkg::DEVICE_TYPE, 1'b0, sh, sl, rw}, e);
  endtask
  task automatic addr(input logic [15:0] a);
    sel(1'b0, 1'b1);
    put(a[15:8], 1'b1);
    put(a[7:0], 1'b1);
  endtask
  task automatic idle(input logic [7:0] eb);
    repeat (20) @(negedge clock_i);
    chk({7'h00, busy}, eb);
  endtask

  // Oldest note against each result as it appears
  always @(res_ev) chk(q.pop_front(), res);

  initial begin
    repeat (80000) @(posedge clock_i);
    num_errors++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] v;
    logic [7:0] good;
    logic [15:0] a;
    logic [7:0] d[65];
    logic s;
    v = rnd();
    sl = v[0];
    sh = v[1];
    good = {eeprom_port_pkg::DEVICE_TYPE, 1'b0, sh, sl, 1'b0};
    repeat (20) @(posedge clock_i);
    @(negedge clock_i) rst_n_i = 1'b1;
    repeat (10) @(negedge clock_i);
    for (int k = 0; k < 4; k++) begin
      m.start();
      put(good ^ (8'h10 >> k), 1'b0);
      m.stop();
    end
    addr(16'h0010);
    put(8'h5A, 1'b0);
    m.stop();
    idle(8'h00);
    addr(16'hFFFF);
    put(eeprom_port_pkg::CTRL_LATCH_SET, 1'b1);
    m.stop();
    idle(8'h00);
    chk({7'h00, store_write_latch}, 8'h01);
    addr(16'hFFFF);
    put(8'h98, 1'b1);
    m.stop();
    idle(8'h01);
    for (int t = 0; t < 2000 && busy === 1'b1; t++) @(negedge clock_i);
    chk({5'h00, gp, bp}, 8'h07);
    wp = 1'b1;
    addr(16'hFFFF);
    put(8'h80, 1'b1);
    m.stop();
    idle(8'h00);
    chk({5'h00, gp, bp}, 8'h07);
    wp = 1'b0;
    v = rnd();
    a = {1'b0, v[6:0], 8'h00};
    v = rnd();
    a[7:0] = {v[1:0], 6'h3E};
    addr(a);
    for (int i = 0; i < 65; i++) begin
      d[i] = rnd();
      put(d[i], 1'b1);
    end
    m.stop();
    idle(8'h01);
    sel(1'b0, 1'b0);
    m.stop();
    for (int t = 0; t < 2000 && busy === 1'b1; t++) @(negedge clock_i);
    addr(a);
    m.stop();
    idle(8'h00);
    addr(a ^ 16'h0040);
    put(8'hC3, 1'b1);
    for (int i = 0; i < 3; i++) m.clk_bit(1'b0, s);
    m.stop();
    idle(8'h00);
    addr(a);
    sel(1'b1, 1'b1);
    get(d[64], 1'b1);
    get(d[1], 1'b0);
    m.stop();
    addr({a[15:6], 6'h00});
    sel(1'b1, 1'b1);
    get(d[2], 1'b1);
    get(d[3], 1'b0);
    m.stop();
    addr(16'hFFFF);
    put(eeprom_port_pkg::CTRL_LATCH_CLR, 1'b1);
    m.stop();
    idle(8'h00);
    chk({7'h00, store_write_latch}, 8'h00);
    repeat (50) @(negedge clock_i);
    conclude();
  end
endmodule
`default_nettype wire
